/* verilog/op_sampler_pkg.sv */
// Shared constants and types of the op execution sampler
package op_sampler_pkg;
  localparam int CNT_W = 27;
  localparam int THR_W = 23;
  localparam int THR_HI_W = 7;
  localparam int THR_LO_W = 16;
  localparam int LAT_W = 16;
  localparam int RND_W = 7;
  localparam int SEL_W = 3;
  // Register select codes on the model-specific register port
  localparam logic [SEL_W-1:0] SEL_CTL = 3'h0;
  localparam logic [SEL_W-1:0] SEL_RIP = 3'h1;
  localparam logic [SEL_W-1:0] SEL_BRANCH = 3'h2;
  localparam logic [SEL_W-1:0] SEL_MEMSYS = 3'h3;
  localparam logic [SEL_W-1:0] SEL_DCACHE = 3'h4;
  // Control register fields
  localparam int CUR_LSB = 32;
  localparam int THR_HI_LSB = 20;
  localparam int SRC_BIT = 19;
  localparam int VALID_BIT = 18;
  localparam int EN_BIT = 17;
  localparam int THR_LO_LSB = 0;
  localparam int THR_CMP_LSB = 4;
  localparam int ABORT_ZERO_LSB = 7;
  // Branch status fields
  localparam int RIP_INV_BIT = 38;
  localparam int BRN_RET_BIT = 37;
  localparam int BRN_MISP_BIT = 36;
  localparam int BRN_TAKEN_BIT = 35;
  localparam int RET_BIT = 34;
  // Data cache status fields
  localparam int LAT_LSB = 32;
  localparam int PHYS_VALID_BIT = 18;
  localparam int LIN_VALID_BIT = 17;
  localparam int LOCKED_BIT = 15;
  localparam int UC_BIT = 14;
  localparam int WC_BIT = 13;
  localparam int MISALIGN_BIT = 8;
  localparam int DC_MISS_BIT = 7;
  localparam int HIT_1G_BIT = 5;
  localparam int HIT_2M_BIT = 4;
  localparam int TLB_MISS_BIT = 2;
  localparam int STORE_BIT = 1;
  localparam int LOAD_BIT = 0;
  // Implemented bits; all others read as zero
  localparam logic [63:0] BRANCH_MASK = 64'h0000_007C_0000_0000;
  localparam logic [63:0] DCACHE_MASK = 64'h0000_FFFF_0006_E1B7;
  // Pseudo-random generator for the abort reload
  localparam logic [RND_W-1:0] RND_SEED = 7'h5A;
  localparam int RND_TAP_A = 6;
  localparam int RND_TAP_B = 5;

  typedef enum logic [1:0] {
    ST_COUNT = 2'b00,
    ST_ARMED = 2'b01,
    ST_TAGGED = 2'b10
  } state_t;

  // Status of the tagged op, presented by the core with its retire pulse
  typedef struct packed {
    logic [63:0] rip;
    logic rip_invalid;
    logic branch_retired;
    logic branch_mispredicted;
    logic branch_taken;
    logic subroutine_return;
    logic [63:0] memsys_data;
    logic phys_data_addr_valid;
    logic lin_data_addr_valid;
    logic locked_access;
    logic uncacheable_access;
    logic write_combining_access;
    logic misaligned_penalty;
    logic data_cache_miss;
    logic tlb_hit_1g;
    logic tlb_hit_2m;
    logic tlb_miss;
    logic store_op;
    logic load_op;
  } retire_info_t;
endpackage

/* verilog/op_execution_sampler.sv */
// Op execution sampling monitor with model-specific register access
// What this block does
// R1 - 27-bit interval counter runs only while enabled and no sample is held.
// R2 - Tagged op abort: no sample, counter 26:7 zeroed, 6:0 random, keep counting.
// R3 - Software reaches these registers only through register read and write.
// R4 - Control bits 58:32 read live count; write clearing valid loads it.
// R5 - Control 26:20 hold threshold top bits, 15:0 hold threshold bits 19:4.
// R6 - Control bit 19 chooses counting clock cycles or dispatched ops.
// R7 - Counter bits 26:4 equal to threshold tags the next op.
// R8 - Tagged op retire sets valid bit 18 and stops the counter.
// R9 - Tagged op retire setting valid raises an interrupt request pulse; a software write of valid does not.
// R10 - Handler reads the sample before clearing valid, which re-arms sampling.
// R11 - Control bit 17 enables sampling when set, disables when clear.
// R12 - Address register captures the tagged op instruction address.
// R13 - Branch status bit 38 flags an invalid captured address.
// R14 - Bits 37, 36, 35 report branch retired, mispredicted, taken.
// R15 - Bit 34 reports a retired subroutine return.
// R16 - Memory system register captures implementation-defined data.
// R17 - A boundary-crossing access reports only the part below 128 bits.
// R18 - Bits 47:32 count cycles from cache miss detect to data delivery.
// R19 - Bits 18 and 17 flag valid physical and linear data addresses.
// R20 - Bits 15, 14, 13 flag locked, uncacheable, write-combining access.
// R21 - Bit 8 flags misalignment penalty, bit 7 a data cache miss.
// R22 - Bits 5, 4, 2 flag TLB hit 1G, hit 2M, TLB miss.
// R23 - Bit 1 flags a store, bit 0 a load.
// R24 - Software writes zero to reserved bits; those read back zero.
`timescale 1ns/1ps
module op_execution_sampler (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic msr_wr,
  input wire logic msr_rd,
  input wire logic [op_sampler_pkg::SEL_W-1:0] msr_sel,
  input wire logic [63:0] msr_wdata,
  output logic [63:0] msr_rdata_q,
  output logic msr_rd_ack_q,
  output logic msr_sel_err_q,
  input wire logic op_dispatch,
  output logic tag_next_q,
  input wire logic tagged_retire,
  input wire logic tagged_abort,
  input wire op_sampler_pkg::retire_info_t retire_info,
  input wire logic dc_miss_detect,
  input wire logic dc_data_deliver,
  output logic irq_q
);
  op_sampler_pkg::state_t st_q;
  logic [op_sampler_pkg::CNT_W-1:0] cnt_q;
  logic [op_sampler_pkg::THR_HI_W-1:0] thr_hi_q;
  logic [op_sampler_pkg::THR_LO_W-1:0] thr_lo_q;
  logic src_q;
  logic en_q;
  logic valid_q;
  logic [op_sampler_pkg::RND_W-1:0] rnd_q;
  logic [op_sampler_pkg::LAT_W-1:0] lat_q;
  logic lat_run_q;
  logic [63:0] rip_q;
  logic [63:0] branch_q;
  logic [63:0] memsys_q;
  logic [63:0] dcache_q;
  logic [63:0] ctl_rd;
  logic [63:0] branch_cap;
  logic [63:0] dcache_cap;
  logic ctl_wr;
  logic rearm_wr;
  logic retire_ev;
  logic abort_ev;
  logic count_adv;
  logic thr_match;

  assign ctl_wr = msr_wr && (msr_sel == op_sampler_pkg::SEL_CTL);
  assign rearm_wr = ctl_wr && !msr_wdata[op_sampler_pkg::VALID_BIT];
  assign retire_ev = (st_q == op_sampler_pkg::ST_TAGGED) && tagged_retire;
  assign abort_ev = (st_q == op_sampler_pkg::ST_TAGGED) && tagged_abort && !tagged_retire;
  assign count_adv = en_q && !valid_q && (st_q == op_sampler_pkg::ST_COUNT) &&
    (src_q ? op_dispatch : 1'b1); // R1 R6
  assign thr_match = en_q && !valid_q && (st_q == op_sampler_pkg::ST_COUNT) &&
    (cnt_q[op_sampler_pkg::CNT_W-1:op_sampler_pkg::THR_CMP_LSB] ==
    {thr_hi_q, thr_lo_q}); // R7

  // Control fields written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      thr_hi_q <= '0;
      thr_lo_q <= '0;
      src_q <= 1'b0;
      en_q <= 1'b0;
    end else if (ctl_wr) begin
      thr_hi_q <= msr_wdata[op_sampler_pkg::THR_HI_LSB +: op_sampler_pkg::THR_HI_W]; // R5
      thr_lo_q <= msr_wdata[op_sampler_pkg::THR_LO_LSB +: op_sampler_pkg::THR_LO_W]; // R5
      src_q <= msr_wdata[op_sampler_pkg::SRC_BIT]; // R6
      en_q <= msr_wdata[op_sampler_pkg::EN_BIT]; // R11
    end
  end

  // Sample-valid flag: a retire in the same cycle as a clearing write wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else if (retire_ev) begin
      valid_q <= 1'b1; // R8
    end else if (ctl_wr) begin
      valid_q <= msr_wdata[op_sampler_pkg::VALID_BIT]; // R10
    end
  end

  // Interrupt request pulse on each new sample
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= retire_ev; // R9
    end
  end

  // Free-running pseudo-random source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rnd_q <= op_sampler_pkg::RND_SEED;
    end else begin
      rnd_q <= {rnd_q[op_sampler_pkg::RND_W-2:0],
        rnd_q[op_sampler_pkg::RND_TAP_A] ^ rnd_q[op_sampler_pkg::RND_TAP_B]};
    end
  end

  // Interval counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (rearm_wr) begin
      cnt_q <= msr_wdata[op_sampler_pkg::CUR_LSB +: op_sampler_pkg::CNT_W]; // R4
    end else if (abort_ev) begin
      cnt_q <= {{(op_sampler_pkg::CNT_W-op_sampler_pkg::RND_W){1'b0}}, rnd_q}; // R2
    end else if (count_adv) begin
      cnt_q <= cnt_q + 27'h1; // R1
    end
  end

  // Tagging sequence; disabling sampling drops any tag in flight
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= op_sampler_pkg::ST_COUNT;
      tag_next_q <= 1'b0;
    end else if (!en_q) begin
      st_q <= op_sampler_pkg::ST_COUNT; // R11
      tag_next_q <= 1'b0;
    end else begin
      case (st_q)
        op_sampler_pkg::ST_COUNT: begin
          if (thr_match && !rearm_wr) begin
            st_q <= op_sampler_pkg::ST_ARMED; // R7
            tag_next_q <= 1'b1;
          end
        end
        op_sampler_pkg::ST_ARMED: begin
          if (op_dispatch) begin
            st_q <= op_sampler_pkg::ST_TAGGED; // R7
            tag_next_q <= 1'b0;
          end
        end
        op_sampler_pkg::ST_TAGGED: begin
          if (tagged_retire || tagged_abort) begin
            st_q <= op_sampler_pkg::ST_COUNT; // R2 R8
          end
        end
        default: begin
          st_q <= op_sampler_pkg::ST_COUNT;
          tag_next_q <= 1'b0;
        end
      endcase
    end
  end

  // Miss latency of the tagged access, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lat_q <= '0;
      lat_run_q <= 1'b0;
    end else if (st_q != op_sampler_pkg::ST_TAGGED) begin
      lat_q <= '0;
      lat_run_q <= 1'b0;
    end else if (dc_miss_detect && !lat_run_q) begin
      lat_q <= '0; // R18
      lat_run_q <= 1'b1;
    end else if (lat_run_q) begin
      if (dc_data_deliver) begin
        lat_run_q <= 1'b0; // R18
      end
      if (lat_q != {op_sampler_pkg::LAT_W{1'b1}}) begin
        lat_q <= lat_q + 16'h1; // R18
      end
    end
  end

  // Capture images of the status registers
  always_comb begin
    branch_cap = '0;
    branch_cap[op_sampler_pkg::RIP_INV_BIT] = retire_info.rip_invalid; // R13
    branch_cap[op_sampler_pkg::BRN_RET_BIT] = retire_info.branch_retired; // R14
    branch_cap[op_sampler_pkg::BRN_MISP_BIT] = retire_info.branch_mispredicted; // R14
    branch_cap[op_sampler_pkg::BRN_TAKEN_BIT] = retire_info.branch_taken; // R14
    branch_cap[op_sampler_pkg::RET_BIT] = retire_info.subroutine_return; // R15
    dcache_cap = '0;
    // The core presents only the lower part of a boundary-crossing access
    dcache_cap[op_sampler_pkg::LAT_LSB +: op_sampler_pkg::LAT_W] = lat_q; // R17 R18
    dcache_cap[op_sampler_pkg::PHYS_VALID_BIT] = retire_info.phys_data_addr_valid; // R19
    dcache_cap[op_sampler_pkg::LIN_VALID_BIT] = retire_info.lin_data_addr_valid; // R19
    dcache_cap[op_sampler_pkg::LOCKED_BIT] = retire_info.locked_access; // R20
    dcache_cap[op_sampler_pkg::UC_BIT] = retire_info.uncacheable_access; // R20
    dcache_cap[op_sampler_pkg::WC_BIT] = retire_info.write_combining_access; // R20
    dcache_cap[op_sampler_pkg::MISALIGN_BIT] = retire_info.misaligned_penalty; // R21
    dcache_cap[op_sampler_pkg::DC_MISS_BIT] = retire_info.data_cache_miss; // R21
    dcache_cap[op_sampler_pkg::HIT_1G_BIT] = retire_info.tlb_hit_1g; // R22
    dcache_cap[op_sampler_pkg::HIT_2M_BIT] = retire_info.tlb_hit_2m; // R22
    dcache_cap[op_sampler_pkg::TLB_MISS_BIT] = retire_info.tlb_miss; // R22
    dcache_cap[op_sampler_pkg::STORE_BIT] = retire_info.store_op; // R23
    dcache_cap[op_sampler_pkg::LOAD_BIT] = retire_info.load_op; // R23
  end

  // Sample registers: capture on retire, else software may overwrite
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rip_q <= '0;
      branch_q <= '0;
      memsys_q <= '0;
      dcache_q <= '0;
    end else if (retire_ev) begin
      rip_q <= retire_info.rip; // R12
      branch_q <= branch_cap; // R13 R14 R15
      memsys_q <= retire_info.memsys_data; // R16
      dcache_q <= dcache_cap; // R19 R20 R21 R22 R23
    end else if (msr_wr) begin
      case (msr_sel)
        op_sampler_pkg::SEL_RIP: rip_q <= msr_wdata;
        op_sampler_pkg::SEL_BRANCH: branch_q <= msr_wdata & op_sampler_pkg::BRANCH_MASK;
        op_sampler_pkg::SEL_MEMSYS: memsys_q <= msr_wdata;
        op_sampler_pkg::SEL_DCACHE: dcache_q <= msr_wdata & op_sampler_pkg::DCACHE_MASK;
        default: begin
        end
      endcase
    end
  end

  // Control register read image; reserved bits read zero
  always_comb begin
    ctl_rd = '0; // R24
    ctl_rd[op_sampler_pkg::CUR_LSB +: op_sampler_pkg::CNT_W] = cnt_q; // R4
    ctl_rd[op_sampler_pkg::THR_HI_LSB +: op_sampler_pkg::THR_HI_W] = thr_hi_q; // R5
    ctl_rd[op_sampler_pkg::SRC_BIT] = src_q;
    ctl_rd[op_sampler_pkg::VALID_BIT] = valid_q;
    ctl_rd[op_sampler_pkg::EN_BIT] = en_q;
    ctl_rd[op_sampler_pkg::THR_LO_LSB +: op_sampler_pkg::THR_LO_W] = thr_lo_q; // R5
  end

  // Read port: answer one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msr_rdata_q <= '0;
      msr_rd_ack_q <= 1'b0;
      msr_sel_err_q <= 1'b0;
    end else begin
      msr_rd_ack_q <= msr_rd;
      msr_sel_err_q <= 1'b0;
      msr_rdata_q <= '0;
      if (msr_rd) begin
        case (msr_sel)
          op_sampler_pkg::SEL_CTL: msr_rdata_q <= ctl_rd;
          op_sampler_pkg::SEL_RIP: msr_rdata_q <= rip_q;
          op_sampler_pkg::SEL_BRANCH: msr_rdata_q <= branch_q;
          op_sampler_pkg::SEL_MEMSYS: msr_rdata_q <= memsys_q;
          op_sampler_pkg::SEL_DCACHE: msr_rdata_q <= dcache_q;
          default: msr_sel_err_q <= 1'b1;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_arm_then_dispatch;
    (st_q == op_sampler_pkg::ST_ARMED) && en_q && op_dispatch ##1
      (st_q == op_sampler_pkg::ST_TAGGED);
  endsequence

  sequence s_tagged_retire;
    (st_q == op_sampler_pkg::ST_TAGGED) && en_q && tagged_retire;
  endsequence

  a_count_frozen: assert property ( // R1
    valid_q && !ctl_wr |=> $stable(cnt_q))
    else $error("counter moved while a sample is held");
  a_abort_reload: assert property ( // R2
    (st_q == op_sampler_pkg::ST_TAGGED) && tagged_abort && !tagged_retire && !ctl_wr
    |=> cnt_q[op_sampler_pkg::CNT_W-1:op_sampler_pkg::ABORT_ZERO_LSB] == '0 && !valid_q)
    else $error("abort did not reload counter upper bits to zero");
  a_current_load: assert property ( // R4
    rearm_wr |=> cnt_q == $past(msr_wdata[op_sampler_pkg::CUR_LSB +: op_sampler_pkg::CNT_W]))
    else $error("current count not loaded on re-arm write");
  a_cycle_count: assert property ( // R6
    en_q && !valid_q && !src_q && (st_q == op_sampler_pkg::ST_COUNT) && !msr_wr
    |=> cnt_q == $past(cnt_q) + 27'h1)
    else $error("cycle mode counter did not advance");
  a_match_tags: assert property ( // R7
    thr_match && !msr_wr |=> tag_next_q ##0 (st_q == op_sampler_pkg::ST_ARMED))
    else $error("threshold match did not arm tagging");
  a_tag_taken: assert property ( // R7
    s_arm_then_dispatch |-> !tag_next_q)
    else $error("tag request held after tagged dispatch");
  a_retire_valid: assert property ( // R8
    s_tagged_retire |=> valid_q ##1 $stable(cnt_q) || $past(ctl_wr))
    else $error("retire did not set valid and stop the counter");
  a_irq_raise: assert property ( // R9
    s_tagged_retire |=> irq_q ##1 !irq_q)
    else $error("sample did not raise a single interrupt pulse");
  a_disable_drops: assert property ( // R11
    !en_q |=> !tag_next_q && (st_q == op_sampler_pkg::ST_COUNT))
    else $error("tagging active while disabled");
  a_rip_flag: assert property ( // R13
    s_tagged_retire |=> branch_q[op_sampler_pkg::RIP_INV_BIT] == $past(retire_info.rip_invalid))
    else $error("address invalid flag not captured");
  a_kind_bits: assert property ( // R23
    s_tagged_retire |=> dcache_q[op_sampler_pkg::STORE_BIT] == $past(retire_info.store_op) &&
    dcache_q[op_sampler_pkg::LOAD_BIT] == $past(retire_info.load_op))
    else $error("load or store kind not captured");
endmodule // op_execution_sampler

/* verif/core_model.sv */
// Behavioural core side: dispatches ops and runs the tagged op to retire or abort
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic dispatch_on,
  input wire logic abort_req,
  input wire logic [7:0] miss_cycles,
  input wire op_sampler_pkg::retire_info_t info,
  input wire logic tag_next_q,
  output logic op_dispatch,
  output logic tagged_retire,
  output logic tagged_abort,
  output op_sampler_pkg::retire_info_t retire_info,
  output logic dc_miss_detect,
  output logic dc_data_deliver
);
  logic go;
  initial begin
    op_dispatch = 1'b0;
    tagged_retire = 1'b0;
    tagged_abort = 1'b0;
    retire_info = '0;
    dc_miss_detect = 1'b0;
    dc_data_deliver = 1'b0;
    forever begin
      @(posedge clk);
      go = dispatch_on;
      #1;
      op_dispatch = go;
      // The op dispatched while the tag request is up is the tagged one
      if (go && tag_next_q === 1'b1) begin
        @(posedge clk);
        #1;
        op_dispatch = 1'b0;
        dc_miss_detect = 1'b1;
        @(posedge clk);
        #1;
        dc_miss_detect = 1'b0;
        repeat (miss_cycles - 1) @(posedge clk);
        #1;
        dc_data_deliver = 1'b1;
        @(posedge clk);
        #1;
        dc_data_deliver = 1'b0;
        tagged_retire = !abort_req;
        tagged_abort = abort_req;
        retire_info = info;
        @(posedge clk);
        #1;
        tagged_retire = 1'b0;
        tagged_abort = 1'b0;
        // Status is only meaningful with the retire pulse
        retire_info = ~info;
      end
    end
  end
endmodule // core_model

/* verif/test_op_execution_sampler.sv */
// Self-checking bench of the op execution sampler
`timescale 1ns/1ps
module test_op_execution_sampler;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic msr_wr = 1'b0;
  logic msr_rd = 1'b0;
  logic [op_sampler_pkg::SEL_W-1:0] msr_sel = '0;
  logic [63:0] msr_wdata = '0;
  logic [63:0] msr_rdata_q;
  logic msr_rd_ack_q, msr_sel_err_q, op_dispatch, tag_next_q, tagged_retire;
  logic tagged_abort, dc_miss_detect, dc_data_deliver, irq_q;
  op_sampler_pkg::retire_info_t retire_info;
  op_sampler_pkg::retire_info_t info = '0;
  logic dispatch_on = 1'b0;
  logic abort_req = 1'b0;
  logic [7:0] miss_cycles = 8'h03;
  logic [63:0] c1, c2, rd;
  int fails = 0;
  int num_checks = 0;
  int n_disp = 0;
  int n_irq = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (op_dispatch === 1'b1) n_disp++;
    if (irq_q === 1'b1) n_irq++;
  end
  op_execution_sampler u_op_execution_sampler (.clk(clk), .sys_rst(sys_rst), .msr_wr(msr_wr),
    .msr_rd(msr_rd), .msr_sel(msr_sel), .msr_wdata(msr_wdata), .msr_rdata_q(msr_rdata_q),
    .msr_rd_ack_q(msr_rd_ack_q), .msr_sel_err_q(msr_sel_err_q), .op_dispatch(op_dispatch),
    .tag_next_q(tag_next_q), .tagged_retire(tagged_retire), .tagged_abort(tagged_abort),
    .retire_info(retire_info), .dc_miss_detect(dc_miss_detect),
    .dc_data_deliver(dc_data_deliver), .irq_q(irq_q));
  core_model u_core_model (.clk(clk), .dispatch_on(dispatch_on), .abort_req(abort_req),
    .miss_cycles(miss_cycles), .info(info), .tag_next_q(tag_next_q), .op_dispatch(op_dispatch),
    .tagged_retire(tagged_retire), .tagged_abort(tagged_abort), .retire_info(retire_info),
    .dc_miss_detect(dc_miss_detect), .dc_data_deliver(dc_data_deliver));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic msr_write(input logic [2:0] sel, input logic [63:0] d);
    // One idle edge keeps a strobe from being lowered and raised in one step
    cycles(1);
    msr_sel = sel;
    msr_wdata = d;
    msr_wr = 1'b1;
    cycles(1);
    msr_wr = 1'b0;
  endtask
  task automatic msr_read(input logic [2:0] sel, output logic [63:0] d);
    cycles(1);
    msr_sel = sel;
    msr_rd = 1'b1;
    cycles(1);
    msr_rd = 1'b0;
    check("read ack", {63'h0, msr_rd_ack_q}, 64'h1);
    d = msr_rdata_q;
  endtask
  task automatic t_reset();
    msr_read(op_sampler_pkg::SEL_CTL, rd);
    check("control after reset", rd, 64'h0);
    check("tag after reset", {63'h0, tag_next_q}, 64'h0);
  endtask
  task automatic t_fields();
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0000_0005_07A8_1234);
    cycles(10);
    msr_read(op_sampler_pkg::SEL_CTL, rd);
    check("control image", rd, 64'h0000_0005_07A8_1234);
    msr_read(3'h5, rd);
    check("unmapped data", rd, 64'h0);
    check("unmapped error", {63'h0, msr_sel_err_q}, 64'h1);
    // Only the documented status bits keep a software write
    msr_write(op_sampler_pkg::SEL_BRANCH, 64'hFFFF_FFFF_FFFF_FFFF);
    msr_read(op_sampler_pkg::SEL_BRANCH, rd);
    check("branch write image", rd, 64'h0000_007C_0000_0000);
    msr_write(op_sampler_pkg::SEL_DCACHE, 64'hFFFF_FFFF_FFFF_FFFF);
    msr_read(op_sampler_pkg::SEL_DCACHE, rd);
    check("cache write image", rd, 64'h0000_FFFF_0006_E1B7);
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0000_0005_07AA_1234);
    cycles(6);
    msr_read(op_sampler_pkg::SEL_CTL, rd);
    check("no ops no count", rd, 64'h0000_0005_07AA_1234);
    n_disp = 0;
    dispatch_on = 1'b1;
    cycles(8);
    dispatch_on = 1'b0;
    cycles(4);
    msr_read(op_sampler_pkg::SEL_CTL, rd);
    check("op count", rd, 64'h0000_0005_07AA_1234 + (64'(n_disp) << 32));
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0);
  endtask
  task automatic t_sample(input op_sampler_pkg::retire_info_t inf, input logic [7:0] m);
    int n;
    info = inf;
    miss_cycles = m;
    n_irq = 0;
    n = 0;
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0000_0000_0002_0001);
    dispatch_on = 1'b1;
    while (irq_q !== 1'b1 && n < 300) begin
      cycles(1);
      n++;
    end
    check("irq raised", {63'h0, irq_q}, 64'h1);
    dispatch_on = 1'b0;
    msr_read(op_sampler_pkg::SEL_CTL, c1);
    check("valid set", {63'h0, c1[op_sampler_pkg::VALID_BIT]}, 64'h1);
    check("count at tag", {41'h0, c1[58:36]}, 64'h1);
    cycles(10);
    msr_read(op_sampler_pkg::SEL_CTL, c2);
    check("count stopped", c2, c1);
    msr_read(op_sampler_pkg::SEL_RIP, rd);
    check("op address", rd, inf.rip);
    msr_read(op_sampler_pkg::SEL_BRANCH, rd);
    check("branch status", rd, {25'h0, inf.rip_invalid, inf.branch_retired,
      inf.branch_mispredicted, inf.branch_taken, inf.subroutine_return, 34'h0});
    msr_read(op_sampler_pkg::SEL_MEMSYS, rd);
    check("memory system", rd, inf.memsys_data);
    msr_read(op_sampler_pkg::SEL_DCACHE, rd);
    check("cache status", rd, {16'h0, 8'h0, m, 13'h0, inf.phys_data_addr_valid,
      inf.lin_data_addr_valid, 1'b0, inf.locked_access, inf.uncacheable_access,
      inf.write_combining_access, 4'h0, inf.misaligned_penalty, inf.data_cache_miss, 1'b0,
      inf.tlb_hit_1g, inf.tlb_hit_2m, 1'b0, inf.tlb_miss, inf.store_op,
      inf.load_op});
    check("one irq", 64'(n_irq), 64'h1);
    // Sample read out before valid is cleared
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0);
  endtask
  task automatic t_abort();
    int n;
    abort_req = 1'b1;
    n_irq = 0;
    n = 0;
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0000_0FF0_0002_00FF);
    dispatch_on = 1'b1;
    while (tagged_abort !== 1'b1 && n < 300) begin
      cycles(1);
      n++;
    end
    dispatch_on = 1'b0;
    cycles(1);
    msr_read(op_sampler_pkg::SEL_CTL, c1);
    check("abort count top", {44'h0, c1[58:39]}, 64'h0);
    check("abort no valid", {63'h0, c1[op_sampler_pkg::VALID_BIT]}, 64'h0);
    cycles(4);
    msr_read(op_sampler_pkg::SEL_CTL, c2);
    check("count resumed", {63'h0, c2[58:32] > c1[58:32]}, 64'h1);
    check("abort no irq", 64'(n_irq), 64'h0);
    abort_req = 1'b0;
    msr_write(op_sampler_pkg::SEL_CTL, 64'h0);
  endtask
  task automatic complete_run();
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_fields();
    t_sample({64'h0000_7FFF_1234_5678, 5'h16, 64'hDEAD_BEEF_0123_4567, 13'h15A9}, 8'h03);
    t_sample({64'hFFFF_8000_0000_1000, 5'h09, 64'h0123_4567_89AB_CDEF, 13'h0A56}, 8'h28);
    t_abort();
    complete_run();
  end
endmodule // test_op_execution_sampler
